// ===== design/mcr_regs.sv
// Summary of operation
// - Status bits 10/9 show reverse/forward run.
// - Status bit 8 mirrors brake pin level, zero in pulse input mode.
// - Status bit 4: drive 0, brake 1.
// - Status bits 2..0 flag temperature, supply faults.
// - Locked values ignore potentiometers, serial only.
// - Lock bits: speed, current, regen, acceleration.
// - Lock register clears on restart.
// - First save register only marks values.
// - First save bit map of saved values.
// - Saved values reload and become locked.
// - Second save write marks and starts saving.
// - Second save bit map of compensation values.
// - Saving halts PWM and refuses commands.
// - Config bits 10/9 select reverse/forward direction.
// - Config bit 4 drive or brake, reset clears.
// - Config bit 3 coast or regenerate.
// - Config bits 2:1 select speed-reset timeout.
// - Config bit 0 enables serial config bits.
// - Second config write one clears bit.
// - Second config bit 7 disables brake function.
// - Second config bits 2:1 select baud rate.
// - Write frame: address, command, two data, checksum.
// - Read reply: two data bytes and checksum.
`timescale 1ns/1ps
`default_nettype none
module mcr_regs
   import mcr_pkg::*;
#(
   parameter int TMO_SHORT_CYC = TMO_SHORT_MS * (CLK_HZ / MS_PER_S),
   parameter int TMO_MID_CYC = TMO_MID_MS * (CLK_HZ / MS_PER_S),
   parameter int TMO_LONG_CYC = TMO_LONG_MS * (CLK_HZ / MS_PER_S),
   parameter logic [REG_W-1:0] CFG2_RESET = 14'h0000
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic cmdWrite,
   input wire logic cmdRead,
   input wire logic [7:0] cmdCode,
   input wire logic [REG_W-1:0] wrData,
   output logic cmdReady,
   output logic rdValid,
   output logic [REG_W-1:0] rdData,
   input wire mcr_sense_s sense,
   input wire logic pulseInputMode,
   input wire logic switchForward,
   input wire logic switchReverse,
   input wire logic speedUpdate,
   input wire logic reloadValid,
   input wire logic [REG_W-1:0] reloadSave1,
   input wire logic [REG_W-1:0] reloadCfg2,
   input wire logic flashDone,
   output logic flashStart,
   output logic [REG_W-1:0] flashSave1,
   output logic [REG_W-1:0] flashSave2,
   output logic [3:0] potIgnore,
   output logic speedZero,
   output mcr_drive_s drive,
   output logic brakeFuncEnable,
   output logic supplyCompEnable,
   output logic pulseMeasRes,
   output logic [1:0] serialBaudSel
);

   initial begin
      if (TMO_SHORT_CYC < 1 || TMO_MID_CYC < 1 || TMO_LONG_CYC < 1 ||
          TMO_LONG_CYC >= (1 << TMO_CNT_W)) begin
         $error("mcr_regs: timeout counts out of range");
      end
   end

   // Maps a save-select word onto the lock bits it implies.
   function automatic logic [3:0] save_to_lock(input logic [REG_W-1:0] sv);
      logic [3:0] lk;
      lk = 4'h0;
      lk[LK_SPEED] = sv[SV1_SPEED];
      lk[LK_AMP] = sv[SV1_AMP];
      lk[LK_REGEN] = sv[SV1_REGEN];
      lk[LK_RAMP] = sv[SV1_RAMP];
      return lk;
   endfunction : save_to_lock

   mcr_state_e state;
   mcr_state_e next_state;
   logic [REG_W-1:0] lockMask;
   logic [REG_W-1:0] save1;
   logic [REG_W-1:0] save2;
   logic [REG_W-1:0] cfg1;
   logic [REG_W-1:0] cfg2;
   logic [TMO_CNT_W-1:0] silenceCnt;
   logic silenceArmed;
   logic [REG_W-1:0] statusWord;
   logic [REG_W-1:0] next_rdData;

   // Commands are taken only outside a flash save.
   assign cmdReady = (state == ST_IDLE);
   wire accept = cmdWrite && cmdReady;
   wire readTake = cmdRead && cmdReady && !cmdWrite;
   wire wrLock = accept && (cmdCode == CMD_WR_LOCK);
   wire wrSave1 = accept && (cmdCode == CMD_WR_SAVE1);
   wire wrSave2 = accept && (cmdCode == CMD_WR_SAVE2);
   wire wrCfg1 = accept && (cmdCode == CMD_WR_CFG1);
   wire wrCfg2 = accept && (cmdCode == CMD_WR_CFG2);

   // Effective direction: serial bits win only while enabled.
   wire serialEn = cfg1[C1_UC];
   wire wantFwd = serialEn ? cfg1[C1_FWD] : switchForward;
   wire wantRev = serialEn ? cfg1[C1_REV] : switchReverse;
   wire runFwd = wantFwd && !wantRev && (state == ST_IDLE);
   wire runRev = wantRev && !wantFwd && (state == ST_IDLE);
   wire brakeSel = serialEn && cfg1[C1_DM];
   wire regenSel = serialEn && cfg1[C1_BM];
   wire [1:0] timeoutSel = serialEn ? cfg1[C1_SRC_HI:C1_SRC_LO] : SRC_NEVER;

   // Drive commands to the PWM stage.
   assign drive.reverseRun = runRev;
   assign drive.forwardRun = runFwd;
   assign drive.brakeMode = brakeSel;
   assign drive.regenBrake = brakeSel && regenSel;
   assign drive.pwmHalt = (state == ST_SAVING);

   // Potentiometers are ignored for every locked value.
   assign potIgnore = lockMask[3:0];
   assign brakeFuncEnable = !cfg2[C2_PINOFF];
   assign supplyCompEnable = cfg2[C2_TOPS];
   assign pulseMeasRes = cfg2[C2_PULSE_MEAS_RESOLUTION];
   assign serialBaudSel = cfg2[C2_USP_HI:C2_USP_LO];
   assign flashSave1 = save1;
   assign flashSave2 = save2;

   // Status word assembled from live state; other bits read zero.
   always_comb begin
      statusWord = ZERO_WORD;
      statusWord[ST_REV] = runRev;
      statusWord[ST_FWD] = runFwd;
      statusWord[ST_BRAKE_PIN] = sense.brakePinLevel && !pulseInputMode;
      statusWord[ST_DRIVE_BRAKE] = brakeSel;
      statusWord[ST_THERMAL] = sense.thermalFault;
      statusWord[ST_SUPPLY_HIGH] = sense.supplyHigh;
      statusWord[ST_SUPPLY_LOW] = sense.supplyLow;
   end

   // Read answer selection; unknown commands answer zero.
   always_comb begin
      case (cmdCode)
         CMD_RD_STATUS: next_rdData = statusWord;
         CMD_RD_LOCK: next_rdData = lockMask;
         CMD_RD_SAVE1: next_rdData = save1;
         CMD_RD_SAVE2: next_rdData = save2;
         CMD_RD_CFG1: next_rdData = cfg1;
         CMD_RD_CFG2: next_rdData = cfg2;
         default: next_rdData = ZERO_WORD;
      endcase
   end

   // Save sequencer: only the second save register starts the flash write.
   always_comb begin
      case (state)
         ST_IDLE: next_state = wrSave2 ? ST_SAVING : ST_IDLE;
         ST_SAVING: next_state = flashDone ? ST_IDLE : ST_SAVING;
         default: next_state = ST_IDLE;
      endcase
   end

   // State and read answer registers.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         rdValid <= 1'b0;
         rdData <= ZERO_WORD;
         flashStart <= 1'b0;
      end else begin
         state <= next_state;
         rdValid <= readTake;
         rdData <= readTake ? next_rdData : rdData;
         flashStart <= wrSave2;
      end
   end

   // Lock register: serial writes, auto-lock on save and on reload.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         lockMask <= ZERO_WORD;
      end else if (reloadValid) begin
         lockMask <= {10'h000, save_to_lock(reloadSave1)};
      end else if (wrLock) begin
         lockMask <= wrData & LOCK_MASK;
      end else if (wrSave2) begin
         lockMask <= lockMask | {10'h000, save_to_lock(save1)};
      end
   end

   // Save-select registers only record which values to store.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         save1 <= ZERO_WORD;
         save2 <= ZERO_WORD;
      end else begin
         if (wrSave1) begin
            save1 <= wrData & SAVE1_MASK;
         end
         if (wrSave2) begin
            save2 <= wrData & SAVE2_MASK;
         end
      end
   end

   // First configuration register: serial writes, cleared on restart.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg1 <= ZERO_WORD;
      end else if (wrCfg1) begin
         cfg1 <= wrData & CFG1_MASK;
      end
   end

   // Second configuration register: write one clears, reload restores.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg2 <= ZERO_WORD;
      end else if (reloadValid) begin
         cfg2 <= (reloadCfg2 | CFG2_RESET) & CFG2_MASK;
      end else if (wrCfg2) begin
         cfg2 <= cfg2 & ~(wrData & CFG2_MASK);
      end
   end

   // Timeout limit for the selected silence window.
   wire [TMO_CNT_W-1:0] tmoLimit =
      (timeoutSel == SRC_SHORT) ? TMO_CNT_W'(TMO_SHORT_CYC) :
      (timeoutSel == SRC_MID) ? TMO_CNT_W'(TMO_MID_CYC) :
      TMO_CNT_W'(TMO_LONG_CYC);
   wire tmoHit = silenceArmed && (timeoutSel != SRC_NEVER) &&
      (silenceCnt >= tmoLimit - TMO_CNT_W'(1));

   // Speed watchdog: fires once per silence, rearmed by a speed update.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         silenceCnt <= '0;
         silenceArmed <= 1'b1;
         speedZero <= 1'b0;
      end else begin
         speedZero <= tmoHit;
         if (speedUpdate || timeoutSel == SRC_NEVER) begin
            silenceCnt <= '0;
            silenceArmed <= 1'b1;
         end else if (tmoHit) begin
            silenceArmed <= 1'b0;
         end else if (silenceArmed) begin
            silenceCnt <= silenceCnt + TMO_CNT_W'(1);
         end
      end
   end

endmodule : mcr_regs
`default_nettype wire

// ===== include/mcr_pkg.sv
package mcr_pkg;
   // Command codes of the register set.
   localparam logic [7:0] CMD_RD_STATUS = 8'h30;
   localparam logic [7:0] CMD_RD_LOCK = 8'h31;
   localparam logic [7:0] CMD_RD_SAVE1 = 8'h32;
   localparam logic [7:0] CMD_RD_SAVE2 = 8'h33;
   localparam logic [7:0] CMD_RD_CFG1 = 8'h34;
   localparam logic [7:0] CMD_RD_CFG2 = 8'h35;
   localparam logic [7:0] CMD_WR_LOCK = 8'h71;
   localparam logic [7:0] CMD_WR_SAVE1 = 8'h72;
   localparam logic [7:0] CMD_WR_SAVE2 = 8'h73;
   localparam logic [7:0] CMD_WR_CFG1 = 8'h74;
   localparam logic [7:0] CMD_WR_CFG2 = 8'h75;

   // Every register value is 14 bits wide.
   localparam int REG_W = 14;
   typedef logic [REG_W-1:0] mcr_word_t;

   // Status bit positions.
   localparam int ST_REV = 10;
   localparam int ST_FWD = 9;
   localparam int ST_BRAKE_PIN = 8;
   localparam int ST_DRIVE_BRAKE = 4;
   localparam int ST_THERMAL = 2;
   localparam int ST_SUPPLY_HIGH = 1;
   localparam int ST_SUPPLY_LOW = 0;

   // Lock bit positions.
   localparam int LK_SPEED = 3;
   localparam int LK_AMP = 2;
   localparam int LK_REGEN = 1;
   localparam int LK_RAMP = 0;
   localparam mcr_word_t LOCK_MASK = 14'h000f;

   // First save-select bit positions and writable mask.
   localparam int SV1_SPEED = 0;
   localparam int SV1_AMP = 2;
   localparam int SV1_REGEN = 3;
   localparam int SV1_RAMP = 4;
   localparam mcr_word_t SAVE1_MASK = 14'h3bfd;
   // Second save register: bits 4..0 writable.
   localparam mcr_word_t SAVE2_MASK = 14'h001f;

   // First configuration bit positions and writable mask.
   localparam int C1_REV = 10;
   localparam int C1_FWD = 9;
   localparam int C1_DM = 4;
   localparam int C1_BM = 3;
   localparam int C1_SRC_HI = 2;
   localparam int C1_SRC_LO = 1;
   localparam int C1_UC = 0;
   localparam mcr_word_t CFG1_MASK = 14'h061f;

   // Second configuration bit positions and implemented mask.
   localparam int C2_TOPS = 8;
   localparam int C2_PINOFF = 7;
   localparam int C2_PULSE_MEAS_RESOLUTION = 6;
   localparam int C2_USP_HI = 2;
   localparam int C2_USP_LO = 1;
   localparam mcr_word_t CFG2_MASK = 14'h01c6;
   localparam mcr_word_t ZERO_WORD = 14'h0000;

   // Speed-reset timeouts in milliseconds.
   localparam int TMO_SHORT_MS = 50;
   localparam int TMO_MID_MS = 500;
   localparam int TMO_LONG_MS = 2800;
   localparam int CLK_HZ = 10000000;
   localparam int MS_PER_S = 1000;
   localparam int TMO_CNT_W = 25;

   // Timeout selector codes.
   localparam logic [1:0] SRC_NEVER = 2'h0;
   localparam logic [1:0] SRC_SHORT = 2'h1;
   localparam logic [1:0] SRC_MID = 2'h2;

   // Measured conditions from the power stage and pins.
   typedef struct packed {
      logic thermalFault;
      logic supplyHigh;
      logic supplyLow;
      logic brakePinLevel;
   } mcr_sense_s;

   // Effective drive commands handed to the PWM stage.
   typedef struct packed {
      logic reverseRun;
      logic forwardRun;
      logic brakeMode;
      logic regenBrake;
      logic pwmHalt;
   } mcr_drive_s;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_SAVING = 1'b1
   } mcr_state_e;
endpackage : mcr_pkg

// ===== bench/mcr_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_regs_props
   import mcr_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic cmdWrite,
   input wire logic cmdRead,
   input wire logic [7:0] cmdCode,
   input wire logic [REG_W-1:0] wrData,
   input wire logic cmdReady,
   input wire logic [REG_W-1:0] rdData,
   input wire mcr_sense_s sense,
   input wire logic pulseInputMode,
   input wire logic reloadValid,
   input wire logic flashDone,
   input wire logic flashStart,
   input wire logic [3:0] potIgnore,
   input wire mcr_drive_s drive,
   input wire logic brakeFuncEnable
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   // Requests that the register set takes at this edge.
   wire rdOk = cmdRead && cmdReady && !cmdWrite;
   wire wrOk = cmdWrite && cmdReady && !reloadValid;
   wire stRd = rdOk && cmdCode == CMD_RD_STATUS;
   // A save trigger and the halted state that must follow it.
   sequence saveReq;
      wrOk && cmdCode == CMD_WR_SAVE2;
   endsequence
   sequence saveRsp;
      flashStart && !cmdReady && drive.pwmHalt;
   endsequence
   chk_save_start: assert property (saveReq |=> saveRsp)
      else $error("save trigger did not start a halted save");
   chk_save1_mark: assert property (wrOk && cmdCode == CMD_WR_SAVE1 |=> !flashStart)
      else $error("first save register started a save");
   chk_halt_run: assert property (!cmdReady |-> !drive.forwardRun && !drive.reverseRun)
      else $error("motor runs during a save");
   chk_ready_back: assert property (!cmdReady && flashDone |=> cmdReady)
      else $error("not ready after save done");
   chk_lock_write: assert property (wrOk && cmdCode == CMD_WR_LOCK |=>
      potIgnore == $past(wrData[3:0]))
      else $error("lock bits not applied");
   chk_status_fault: assert property (stRd |=> rdData[2:0] == $past(sense[3:1]))
      else $error("fault flags wrong in status");
   chk_brake_pin: assert property (stRd |=> rdData[ST_BRAKE_PIN] ==
      ($past(sense.brakePinLevel) && !$past(pulseInputMode)))
      else $error("brake pin level wrong in status");
   chk_cfg2_clear: assert property (wrOk && cmdCode == CMD_WR_CFG2 |=>
      brakeFuncEnable == ($past(brakeFuncEnable) | $past(wrData[C2_PINOFF])))
      else $error("second config bit 7 not write one clear");
endmodule : mcr_regs_props
`default_nettype wire

// ===== bench/mcr_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_flash_model #(
   parameter int DELAY = 6
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic flashStart,
   output logic flashDone
);
   int busyCnt;
   // Counts a save down and pulses done once at its end, as slow flash does.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         busyCnt <= 0;
         flashDone <= 1'b0;
      end else begin
         flashDone <= (busyCnt == 1);
         busyCnt <= flashStart ? DELAY : (busyCnt > 0 ? busyCnt - 1 : 0);
      end
   end
endmodule : mcr_flash_model
`default_nettype wire

// ===== bench/motor_ctrl_status_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module motor_ctrl_status_config_regs_tb
   import mcr_pkg::*;
;
   typedef struct packed {
      logic [7:0] wc;
      mcr_word_t wd;
      logic [7:0] rc;
      mcr_word_t ex;
   } mcr_row_s;
   // Each row writes one register and reads back the expected word of that register or of the status register.
   mcr_row_s rows [8] = '{
      '{CMD_WR_LOCK, 14'h3fff, CMD_RD_LOCK, 14'h000f},
      '{CMD_WR_SAVE1, 14'h3fff, CMD_RD_SAVE1, 14'h3bfd},
      '{CMD_WR_CFG1, 14'h3fff, CMD_RD_CFG1, 14'h061f},
      '{CMD_WR_CFG1, 14'h0218, CMD_RD_CFG1, 14'h0218},
      '{CMD_WR_LOCK, 14'h0000, CMD_RD_LOCK, 14'h0000},
      '{CMD_WR_CFG1, 14'h0218, CMD_RD_STATUS, 14'h0107},
      '{CMD_WR_CFG1, 14'h0211, CMD_RD_STATUS, 14'h0317},
      '{CMD_WR_CFG1, 14'h0401, CMD_RD_STATUS, 14'h0507}};
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic cmdWrite = 1'b0, cmdRead = 1'b0, pwmIn = 1'b0, spdUpd = 1'b0, rldValid = 1'b0;
   logic [7:0] cmdCode = 8'h00;
   mcr_word_t wrData = 14'h0000, rldSave1 = 14'h0000, rldCfg2 = 14'h0000;
   mcr_word_t rdData, save1, save2;
   mcr_sense_s sense = 4'hf;
   mcr_drive_s drive;
   logic cmdReady, rdValid, flashStart, flashDone, speedZero, brakeEn;
   logic swFwd = 1'b0, swRev = 1'b0, supComp, pmesRes;
   logic [3:0] potIgnore;
   logic [1:0] baud;
   int n_errors = 0, tests_run = 0, cyc = 0, n;
   always #50 core_clk = ~core_clk;
   mcr_regs #(.TMO_SHORT_CYC(20)) i_dut (.core_clk(core_clk), .arst_n(arst_n),
      .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode), .wrData(wrData),
      .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData), .sense(sense),
      .pulseInputMode(pwmIn), .switchForward(swFwd), .switchReverse(swRev),
      .speedUpdate(spdUpd), .reloadValid(rldValid), .reloadSave1(rldSave1),
      .reloadCfg2(rldCfg2), .flashDone(flashDone), .flashStart(flashStart),
      .flashSave1(save1), .flashSave2(save2), .potIgnore(potIgnore),
      .speedZero(speedZero), .drive(drive), .brakeFuncEnable(brakeEn),
      .supplyCompEnable(supComp), .pulseMeasRes(pmesRes), .serialBaudSel(baud));
   mcr_flash_model i_flash (.core_clk(core_clk), .arst_n(arst_n),
      .flashStart(flashStart), .flashDone(flashDone));
   task automatic chk(input string what, input mcr_word_t seen, input mcr_word_t exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] code, input mcr_word_t data);
      @(negedge core_clk);
      cmdWrite = 1'b1;
      cmdCode = code;
      wrData = data;
      @(negedge core_clk);
      cmdWrite = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] code, input mcr_word_t exp);
      @(negedge core_clk);
      cmdRead = 1'b1;
      cmdCode = code;
      @(negedge core_clk);
      cmdRead = 1'b0;
      chk($sformatf("read %h", code), rdValid ? rdData : 14'h3fff, exp);
   endtask : rd
   task automatic final_report();
      if (n_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   // Cuts a hung run short.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         final_report();
      end
   end
   // Main sequence: reset values, reload, table, status, watchdog, save, reset.
   initial begin
      repeat (8) @(negedge core_clk);
      arst_n = 1'b1;
      for (int c = 8'h31; c <= 8'h35; c++) begin
         rd(8'(c), ZERO_WORD);
      end
      chk("brake enable", 14'(brakeEn), 14'h0001);
      chk("baud", 14'(baud), 14'h0000);
      rldSave1 = 14'h0001;
      rldCfg2 = CFG2_MASK;
      rldValid = 1'b1;
      @(negedge core_clk);
      rldValid = 1'b0;
      rd(CMD_RD_LOCK, 14'h0008);
      rd(CMD_RD_CFG2, 14'h01c6);
      chk("brake enable", 14'(brakeEn), 14'h0000);
      chk("supply comp", 14'(supComp), 14'h0001);
      chk("pulse resolution", 14'(pmesRes), 14'h0001);
      wr(CMD_WR_CFG2, 14'h0082);
      rd(CMD_RD_CFG2, 14'h0144);
      chk("baud", 14'(baud), 14'h0002);
      chk("supply comp kept", 14'(supComp), 14'h0001);
      foreach (rows[i]) begin
         wr(rows[i].wc, rows[i].wd);
         rd(rows[i].rc, rows[i].ex);
      end
      pwmIn = 1'b1;
      rd(CMD_RD_STATUS, 14'h0407);
      pwmIn = 1'b0;
      // Serial control off: the direction switches decide the run flags.
      wr(CMD_WR_CFG1, 14'h0000);
      swFwd = 1'b1;
      rd(CMD_RD_STATUS, 14'h0307);
      swRev = 1'b1;
      rd(CMD_RD_STATUS, 14'h0107);
      swFwd = 1'b0;
      rd(CMD_RD_STATUS, 14'h0507);
      swRev = 1'b0;
      wr(CMD_WR_CFG1, 14'h0003);
      @(negedge core_clk);
      spdUpd = 1'b1;
      @(negedge core_clk);
      spdUpd = 1'b0;
      n = 0;
      while (speedZero !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      chk("silence timeout", 14'(n >= 17 && n <= 23), 14'h0001);
      wr(CMD_WR_SAVE1, 14'h001d);
      rd(CMD_RD_LOCK, 14'h0000);
      wr(CMD_WR_SAVE2, 14'h3fff);
      chk("ready in save", 14'(cmdReady), 14'h0000);
      chk("save1 word", save1, 14'h001d);
      chk("save2 word", save2, 14'h001f);
      wr(CMD_WR_CFG1, 14'h0000);
      n = 0;
      while (cmdReady !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      rd(CMD_RD_CFG1, 14'h0003);
      rd(CMD_RD_LOCK, 14'h000f);
      arst_n = 1'b0;
      @(negedge core_clk);
      arst_n = 1'b1;
      rd(CMD_RD_LOCK, 14'h0000);
      rd(CMD_RD_CFG1, 14'h0000);
      final_report();
   end
endmodule : motor_ctrl_status_config_regs_tb
bind mcr_regs mcr_regs_props i_props (.core_clk(core_clk), .arst_n(arst_n),
   .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode), .wrData(wrData),
   .cmdReady(cmdReady), .rdData(rdData), .sense(sense), .pulseInputMode(pulseInputMode),
   .reloadValid(reloadValid), .flashDone(flashDone), .flashStart(flashStart),
   .potIgnore(potIgnore), .drive(drive), .brakeFuncEnable(brakeFuncEnable));
`default_nettype wire
